// File: core/vcmp_control.sv
// comparator control logic: registers, edge events, routing and low power
//
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - software picks rising, falling or both edges
// - option to compare against internal reference
// - debug pin enable off frees shared pin
// - capture route feeds result to timer channel
// - capture route hides timer channel pin externally
// - comparator keeps running in wait mode
// - enabled event interrupt wakes processor from wait
// - comparator disabled in every stop level
// - deep stop levels return status and control fields to reset
// - light stop halts clocks, keeps registers
// - reset out of light stop resets block
// - writing run to the low power register resumes exact held state
// - debug mode leaves block running normally
// - edge field: 00 fall, 01 rise, 10 fall, 11 both
// - event sets flag, write one clears it
// - interrupt asserted while flag and enable set
module vcmp_control #(
   parameter int ADDR_W = vcmp_pkg::ADDR_BITS
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic              compareRaw,
   input  wire logic              waitMode,
   input  wire logic              debugActive,
   output logic                   compareIrq,
   output logic                   compareEnable,
   output logic                   referenceSelect,
   output logic                   referenceBufferEnable,
   output logic                   compareOutputPin,
   output logic                   compareOutputPinOe,
   output logic                   debugPinEnable,
   output logic                   captureInput,
   output logic                   timerPinBlock
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   vcmp_pkg::vcmp_power_e powerLevel;
   vcmp_pkg::vcmp_power_e next_powerLevel;
   logic              comparatorEnableBit;
   logic              referenceSelectBit;
   logic              compareEventFlag;
   logic              compareIrqEnable;
   logic              resultPinEnable;
   logic [1:0]        edgeSelectField;
   logic              debugPinEnableBit;
   logic              captureRouteBit;
   logic              referenceBufferBit;
   logic              next_comparatorEnableBit;
   logic              next_referenceSelectBit;
   logic              next_compareEventFlag;
   logic              next_compareIrqEnable;
   logic              next_resultPinEnable;
   logic [1:0]        next_edgeSelectField;
   logic              next_debugPinEnableBit;
   logic              next_captureRouteBit;
   logic              next_referenceBufferBit;
   logic              dataPhase;
   logic              dataWrite;
   logic [ADDR_W-1:0] dataAddr;
   logic              next_dataPhase;
   logic              next_dataWrite;
   logic [ADDR_W-1:0] next_dataAddr;
   logic [31:0]       next_hrdata;
   logic              next_compareIrq;
   logic              next_outPin;
   logic              next_outPinOe;
   logic              next_capture;
   logic              compareActive;
   logic              haltClocks;
   logic              compareEvent;
   logic              flagClear;
   logic              addrPhase;
   vcmp_sync_if       syncBus ();

   // ----------------------------------------------------------------
   // result synchroniser
   // ----------------------------------------------------------------
   // halting clocks in light stop keeps synchroniser history too
   assign haltClocks    = (powerLevel == vcmp_pkg::VCMP_STOP3);
   // waitMode and debugActive gate nothing: block runs on in both
   assign compareActive = comparatorEnableBit && (powerLevel == vcmp_pkg::VCMP_RUN);

   vcmp_edge_sync u_sync (
      .clk     (clk),
      .nrst    (nrst),
      .active  (comparatorEnableBit),
      .hold    (haltClocks),
      .rawIn   (compareRaw),
      .syncOut (syncBus)
   );

   // edge choice
   always_comb begin
      unique case (edgeSelectField)
         vcmp_pkg::EDGE_RISE:   compareEvent = syncBus.rise;
         vcmp_pkg::EDGE_BOTH:   compareEvent = syncBus.rise || syncBus.fall;
         vcmp_pkg::EDGE_FALL_A: compareEvent = syncBus.fall;
         vcmp_pkg::EDGE_FALL_B: compareEvent = syncBus.fall;
      endcase
      // no events outside run or while off
      if (!compareActive) begin
         compareEvent = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // bus address and data phase tracking
   // ----------------------------------------------------------------
   assign addrPhase = hsel && hready &&
                      (htrans == vcmp_pkg::HTRANS_NONSEQ || htrans == vcmp_pkg::HTRANS_SEQ);
   assign flagClear = dataPhase && dataWrite && (dataAddr == vcmp_pkg::STATUS_CTRL_ADDR) &&
                      hwdata[vcmp_pkg::BIT_FLAG];

   always_comb begin
      next_dataPhase = addrPhase;
      next_dataWrite = addrPhase && hwrite;
      next_dataAddr  = addrPhase ? haddr : dataAddr;
   end

   // ----------------------------------------------------------------
   // register writes and flag
   // ----------------------------------------------------------------
   always_comb begin
      next_comparatorEnableBit = comparatorEnableBit;
      next_referenceSelectBit  = referenceSelectBit;
      next_compareIrqEnable    = compareIrqEnable;
      next_resultPinEnable     = resultPinEnable;
      next_edgeSelectField     = edgeSelectField;
      next_debugPinEnableBit   = debugPinEnableBit;
      next_captureRouteBit     = captureRouteBit;
      next_referenceBufferBit  = referenceBufferBit;
      next_powerLevel          = powerLevel;
      next_compareEventFlag    = compareEventFlag;
      if (dataPhase && dataWrite) begin
         unique case (dataAddr)
            vcmp_pkg::STATUS_CTRL_ADDR: begin
               next_comparatorEnableBit = hwdata[vcmp_pkg::BIT_ENABLE];
               next_referenceSelectBit  = hwdata[vcmp_pkg::BIT_REF_SEL];
               next_compareIrqEnable    = hwdata[vcmp_pkg::BIT_IRQ_EN];
               next_resultPinEnable     = hwdata[vcmp_pkg::BIT_PIN_EN];
               next_edgeSelectField     = hwdata[vcmp_pkg::BIT_EDGE_HI:vcmp_pkg::BIT_EDGE_LO];
            end
            vcmp_pkg::SYS_OPTIONS_ADDR: begin
               next_debugPinEnableBit = hwdata[vcmp_pkg::BIT_DEBUG_PIN];
               next_captureRouteBit   = hwdata[vcmp_pkg::BIT_CAPTURE];
            end
            vcmp_pkg::POWER_MGMT_ADDR: begin
               next_referenceBufferBit = hwdata[vcmp_pkg::BIT_REF_BUF];
            end
            vcmp_pkg::LOW_POWER_ADDR: begin
               // 0 run, 1 deep stop, 2 light stop; 3 is ignored
               if (hwdata[1:0] == 2'b01) begin
                  next_powerLevel = vcmp_pkg::VCMP_STOP12;
               end else if (hwdata[1:0] == 2'b10) begin
                  next_powerLevel = vcmp_pkg::VCMP_STOP3;
               end else if (hwdata[1:0] == 2'b00) begin
                  next_powerLevel = vcmp_pkg::VCMP_RUN;
               end
            end
            default: begin
            end
         endcase
      end
      // set wins over a clear in the same cycle
      if (flagClear) begin
         next_compareEventFlag = 1'b0;
      end
      if (compareEvent) begin
         next_compareEventFlag = 1'b1;
      end
      // deep stop holds every status and control field at reset while it lasts
      if (powerLevel == vcmp_pkg::VCMP_STOP12) begin
         next_comparatorEnableBit = 1'b0;
         next_referenceSelectBit  = 1'b0;
         next_compareIrqEnable    = 1'b0;
         next_resultPinEnable     = 1'b0;
         next_edgeSelectField     = vcmp_pkg::EDGE_FALL_A;
         next_compareEventFlag    = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read data and outputs
   // ----------------------------------------------------------------
   always_comb begin
      next_hrdata = 32'h0000_0000;
      if (addrPhase && !hwrite) begin
         unique case (haddr)
            vcmp_pkg::STATUS_CTRL_ADDR: begin
               next_hrdata[vcmp_pkg::BIT_ENABLE]  = comparatorEnableBit;
               next_hrdata[vcmp_pkg::BIT_REF_SEL] = referenceSelectBit;
               next_hrdata[vcmp_pkg::BIT_FLAG]    = compareEventFlag;
               next_hrdata[vcmp_pkg::BIT_IRQ_EN]  = compareIrqEnable;
               next_hrdata[vcmp_pkg::BIT_RESULT]  = syncBus.level;
               next_hrdata[vcmp_pkg::BIT_PIN_EN]  = resultPinEnable;
               next_hrdata[vcmp_pkg::BIT_EDGE_HI:vcmp_pkg::BIT_EDGE_LO] = edgeSelectField;
            end
            vcmp_pkg::SYS_OPTIONS_ADDR: begin
               next_hrdata[vcmp_pkg::BIT_DEBUG_PIN] = debugPinEnableBit;
               next_hrdata[vcmp_pkg::BIT_CAPTURE]   = captureRouteBit;
            end
            vcmp_pkg::POWER_MGMT_ADDR: begin
               next_hrdata[vcmp_pkg::BIT_REF_BUF] = referenceBufferBit;
            end
            vcmp_pkg::LOW_POWER_ADDR: begin
               next_hrdata[1:0] = (powerLevel == vcmp_pkg::VCMP_STOP3) ? 2'b10 :
                                  (powerLevel == vcmp_pkg::VCMP_STOP12) ? 2'b01 : 2'b00;
            end
            default: begin
            end
         endcase
      end
      // interrupt follows flag in wait and debug alike
      next_compareIrq = next_compareEventFlag && next_compareIrqEnable;
      // pin only usable once debug function is released
      next_outPinOe   = next_resultPinEnable && !next_debugPinEnableBit;
      next_outPin     = next_outPinOe && syncBus.level;
      next_capture    = next_captureRouteBit && syncBus.level;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // reset path also covers a reset out of light stop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         powerLevel           <= vcmp_pkg::VCMP_RUN;
         comparatorEnableBit  <= 1'b0;
         referenceSelectBit   <= 1'b0;
         compareEventFlag     <= 1'b0;
         compareIrqEnable     <= 1'b0;
         resultPinEnable      <= 1'b0;
         edgeSelectField      <= vcmp_pkg::EDGE_FALL_A;
         debugPinEnableBit    <= vcmp_pkg::DEBUG_PIN_RESET;
         captureRouteBit      <= 1'b0;
         referenceBufferBit   <= 1'b0;
         dataPhase            <= 1'b0;
         dataWrite            <= 1'b0;
         dataAddr             <= '0;
         hrdata               <= 32'h0000_0000;
         compareIrq           <= 1'b0;
         compareOutputPin     <= 1'b0;
         compareOutputPinOe   <= 1'b0;
         captureInput         <= 1'b0;
      end else begin
         powerLevel           <= next_powerLevel;
         comparatorEnableBit  <= next_comparatorEnableBit;
         referenceSelectBit   <= next_referenceSelectBit;
         compareEventFlag     <= next_compareEventFlag;
         compareIrqEnable     <= next_compareIrqEnable;
         resultPinEnable      <= next_resultPinEnable;
         edgeSelectField      <= next_edgeSelectField;
         debugPinEnableBit    <= next_debugPinEnableBit;
         captureRouteBit      <= next_captureRouteBit;
         referenceBufferBit   <= next_referenceBufferBit;
         dataPhase            <= next_dataPhase;
         dataWrite            <= next_dataWrite;
         dataAddr             <= next_dataAddr;
         hrdata               <= next_hrdata;
         compareIrq           <= next_compareIrq;
         compareOutputPin     <= next_outPin;
         compareOutputPinOe   <= next_outPinOe;
         captureInput         <= next_capture;
      end
   end

   // register views, enable gated to run; slave never stalls and always says okay
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout             <= 1'b1;
         hresp                 <= 1'b0;
         compareEnable         <= 1'b0;
         referenceSelect       <= 1'b0;
         referenceBufferEnable <= 1'b0;
         debugPinEnable        <= vcmp_pkg::DEBUG_PIN_RESET;
         timerPinBlock         <= 1'b0;
      end else begin
         hreadyout             <= 1'b1;
         hresp                 <= 1'b0;
         compareEnable         <= next_comparatorEnableBit && (next_powerLevel == vcmp_pkg::VCMP_RUN);
         referenceSelect       <= next_referenceSelectBit;
         referenceBufferEnable <= next_referenceBufferBit;
         debugPinEnable        <= next_debugPinEnableBit;
         timerPinBlock         <= next_captureRouteBit;
      end
   end
endmodule

// File: core/vcmp_pkg.sv
// package of constants and types for the comparator control logic
package vcmp_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_CTRL_ADDR  = 8'h00;
   localparam logic [7:0] SYS_OPTIONS_ADDR  = 8'h04;
   localparam logic [7:0] POWER_MGMT_ADDR   = 8'h08;
   localparam logic [7:0] LOW_POWER_ADDR    = 8'h0c;
   // ----------------------------------------------------------------
   // status and control field positions
   // ----------------------------------------------------------------
   localparam int BIT_ENABLE     = 7;
   localparam int BIT_REF_SEL    = 6;
   localparam int BIT_FLAG       = 5;
   localparam int BIT_IRQ_EN     = 4;
   localparam int BIT_RESULT     = 3;
   localparam int BIT_PIN_EN     = 2;
   localparam int BIT_EDGE_HI    = 1;
   localparam int BIT_EDGE_LO    = 0;
   // system options fields
   localparam int BIT_DEBUG_PIN  = 0;
   localparam int BIT_CAPTURE    = 1;
   // power management field
   localparam int BIT_REF_BUF    = 0;
   // ----------------------------------------------------------------
   // reset values and encodings
   // ----------------------------------------------------------------
   localparam logic       DEBUG_PIN_RESET = 1'b1;
   localparam logic [1:0] EDGE_FALL_A     = 2'b00;
   localparam logic [1:0] EDGE_RISE       = 2'b01;
   localparam logic [1:0] EDGE_FALL_B     = 2'b10;
   localparam logic [1:0] EDGE_BOTH       = 2'b11;
   localparam logic [1:0] HTRANS_NONSEQ   = 2'b10;
   localparam logic [1:0] HTRANS_SEQ      = 2'b11;
   localparam int         ADDR_BITS       = 8;
   // low power levels
   typedef enum logic [1:0] {VCMP_RUN, VCMP_STOP12, VCMP_STOP3} vcmp_power_e;
endpackage

// File: core/vcmp_sync_if.sv
// interface carrying the synchronised comparison result between modules
`timescale 1ns/1ps
interface vcmp_sync_if;
   logic level;
   logic rise;
   logic fall;
   modport source (output level, output rise, output fall);
   modport sink   (input  level, input  rise, input  fall);
endinterface

// File: core/vcmp_edge_sync.sv
// three-stage synchroniser and edge detector for the comparison result
`timescale 1ns/1ps
module vcmp_edge_sync (
   input  wire logic   clk,
   input  wire logic   nrst,
   input  wire logic   active,
   input  wire logic   hold,
   input  wire logic   rawIn,
   vcmp_sync_if.source syncOut
);
   logic stageA;
   logic stageB;
   logic stageC;
   logic last;
   logic next_stageA;
   logic next_stageB;
   logic next_stageC;
   logic next_last;
   logic agreed;
   logic [2:0] filled;
   logic [2:0] next_filled;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   // stages clear while disabled, except under hold in light stop, so the result reads zero at once
   always_comb begin
      next_stageA = active ? rawIn  : 1'b0;
      next_stageB = active ? stageA : 1'b0;
      next_stageC = active ? stageB : 1'b0;
      next_last   = last;
      next_filled = active ? {filled[1:0], 1'b1} : '0;
      if (!active) begin
         next_last = 1'b0;
      end else if (!filled[2] || stageB == stageC) begin
         // until stages refill, history follows quietly
         next_last = stageB;
      end
      if (hold) begin
         // clocks halted: keep everything as it was
         next_stageA = stageA;
         next_stageB = stageB;
         next_stageC = stageC;
         next_last   = last;
         next_filled = filled;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stageA <= 1'b0;
         stageB <= 1'b0;
         stageC <= 1'b0;
         last   <= 1'b0;
         filled <= '0;
      end else begin
         stageA <= next_stageA;
         stageB <= next_stageB;
         stageC <= next_stageC;
         last   <= next_last;
         filled <= next_filled;
      end
   end

   // a change counts only once the two later stages agree
   assign agreed        = (stageB == stageC);
   assign syncOut.level = last;
   assign syncOut.rise  = active && !hold && filled[2] && agreed && stageB && !last;
   assign syncOut.fall  = active && !hold && filled[2] && agreed && !stageB && last;
endmodule

// File: dv/vcmp_control_sva.sv
// concurrent checks on the comparator control ports
`timescale 1ns/1ps
module vcmp_control_sva #(
   parameter int ADDR_W = vcmp_pkg::ADDR_BITS
) (
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic              compareRaw,
   input wire logic              waitMode,
   input wire logic              debugActive,
   input wire logic              compareIrq,
   input wire logic              compareEnable,
   input wire logic              referenceSelect,
   input wire logic              referenceBufferEnable,
   input wire logic              compareOutputPin,
   input wire logic              compareOutputPinOe,
   input wire logic              debugPinEnable,
   input wire logic              captureInput,
   input wire logic              timerPinBlock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ---------------------------------------------------------------
   // bus phases
   // ---------------------------------------------------------------
   // write address phase to one place, followed by its data phase
   sequence s_wr(logic [ADDR_W-1:0] a);
      hsel && hready && htrans[1] && hwrite && haddr == a ##1 1'b1;
   endsequence
   // write lands at the data phase end
   chk_pm_write: assert property (s_wr(ADDR_W'(vcmp_pkg::POWER_MGMT_ADDR)) |->
      ##2 referenceBufferEnable == $past(hwdata[vcmp_pkg::BIT_REF_BUF], 2))
      else $error("reference buffer bit did not follow its write");
   chk_opts_write: assert property (s_wr(ADDR_W'(vcmp_pkg::SYS_OPTIONS_ADDR)) |->
      ##2 debugPinEnable == $past(hwdata[vcmp_pkg::BIT_DEBUG_PIN], 2))
      else $error("debug pin bit did not follow its write");
   chk_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
      |-> hrdata == 32'h0) else $error("read data outside a read data phase");
   chk_hresp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   chk_ready_high: assert property (hreadyout) else $error("slave inserted a wait state");
   // ---------------------------------------------------------------
   // pins and routing
   // ---------------------------------------------------------------
   chk_pin_oe_debug: assert property (compareOutputPinOe |-> !debugPinEnable)
      else $error("output pin driven while debug pin enabled");
   chk_capture_gate: assert property (!timerPinBlock |-> !captureInput)
      else $error("capture input active without route");
   // raw must pass the synchroniser before reaching the timer
   chk_sync_delay: assert property ($rose(captureInput) |->
      $past(compareRaw, 2) && $past(compareRaw, 3))
      else $error("capture input rose without a synchronised raw level");
endmodule

bind vcmp_control vcmp_control_sva #(.ADDR_W(ADDR_W)) i_vcmp_control_sva (.*);

// File: dv/vcmp_analog_model.sv
// behavioural model of the analog comparator in front of the block
`timescale 1ns/1ps
module vcmp_analog_model (
   input  wire logic clk,
   input  wire logic extAbove,
   input  wire logic refAbove,
   input  wire logic compareEnable,
   input  wire logic referenceSelect,
   input  wire logic referenceBufferEnable,
   output logic      compareRaw
);
   logic junk = 1'b0;
   // ---------------------------------------------------------------
   // output stage
   // ---------------------------------------------------------------
   // off or unbuffered: meaningless toggling level
   always @(posedge clk) begin
      junk <= ~junk;
   end
   assign compareRaw = (!compareEnable || (referenceSelect && !referenceBufferEnable)) ? junk :
                       (referenceSelect ? refAbove : extAbove);
endmodule

// File: dv/vcmp_control_tb_top.sv
// self-checking bench for the comparator control logic
`timescale 1ns/1ps
module vcmp_control_tb_top;
   // ---------------------------------------------------------------
   // signals, instances, clock
   // ---------------------------------------------------------------
   typedef struct {logic [1:0] mode; logic rise; logic fall;} vcmp_row_s;
   localparam logic [7:0] CT = vcmp_pkg::STATUS_CTRL_ADDR;
   localparam logic [7:0] OP = vcmp_pkg::SYS_OPTIONS_ADDR;
   localparam logic [7:0] PM = vcmp_pkg::POWER_MGMT_ADDR;
   localparam logic [7:0] LP = vcmp_pkg::LOW_POWER_ADDR;
   localparam logic [31:0] EN = 32'h1 << vcmp_pkg::BIT_ENABLE;
   localparam logic [31:0] RS = 32'h1 << vcmp_pkg::BIT_REF_SEL;
   localparam logic [31:0] FL = 32'h1 << vcmp_pkg::BIT_FLAG;
   localparam logic [31:0] IE = 32'h1 << vcmp_pkg::BIT_IRQ_EN;
   localparam logic [31:0] RE = 32'h1 << vcmp_pkg::BIT_RESULT;
   localparam logic [31:0] PE = 32'h1 << vcmp_pkg::BIT_PIN_EN;
   localparam logic [31:0] BO = 32'h3;
   vcmp_row_s   rows [4] = '{'{vcmp_pkg::EDGE_FALL_A, 1'b0, 1'b1}, '{vcmp_pkg::EDGE_RISE, 1'b1, 1'b0},
                             '{vcmp_pkg::EDGE_FALL_B, 1'b0, 1'b1}, '{vcmp_pkg::EDGE_BOTH, 1'b1, 1'b1}};
   logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic        hreadyout, hresp, compareRaw, waitMode = 1'b0, debugActive = 1'b0, compareIrq;
   logic        compareEnable, referenceSelect, referenceBufferEnable, compareOutputPin;
   logic        compareOutputPinOe, debugPinEnable, captureInput, timerPinBlock;
   logic        extAbove = 1'b0, refAbove = 1'b0;
   int          fails = 0, samples_checked = 0;
   vcmp_control i_vcmp_control (.hready(hreadyout), .*);
   vcmp_analog_model i_vcmp_analog_model (.*);
   initial begin
      forever #4 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // bounded wait for hready
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 40) begin
            chk("hreadyout", 32'h1, 32'h0);
            complete_run();
         end
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= vcmp_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      bus(a, 1'b0, 32'h0);
      chk(nm, e, rd & m);
   endtask
   // the raw level needs a few edges to clear the synchroniser
   task automatic raw(input logic v);
      @(posedge clk);
      extAbove <= v;
      cyc(10);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      cyc(12);
      nrst <= 1'b1;
      chk("debugPinEnable", 32'h1, {31'h0, debugPinEnable});
      rdc("ctrl reset", CT, 32'hff, 32'h0);
      rdc("opts reset", OP, 32'h3, 32'h1);
      rdc("power reset", PM, 32'h1, 32'h0);
      bus(8'h10, 1'b1, 32'hffffffff);
      rdc("unmapped", 8'h10, 32'hffffffff, 32'h0);
      $display("test reset done");
      // each edge mode against one rise and one fall
      foreach (rows[i]) begin
         raw(1'b0);
         bus(CT, 1'b1, EN | FL | rows[i].mode);
         raw(1'b1);
         rdc("flag rise", CT, FL | RE, (rows[i].rise ? FL : 32'h0) | RE);
         bus(CT, 1'b1, EN | FL | rows[i].mode);
         raw(1'b0);
         rdc("flag fall", CT, FL | RE, rows[i].fall ? FL : 32'h0);
      end
      $display("test edge table done");
      bus(CT, 1'b1, FL);
      raw(1'b1);
      rdc("disabled", CT, FL | RE, 32'h0);
      bus(CT, 1'b1, EN | BO);
      cyc(10);
      rdc("enable", CT, FL | RE, RE);
      $display("test enable done");
      waitMode <= 1'b1;
      debugActive <= 1'b1;
      bus(CT, 1'b1, EN | IE | FL | BO);
      cyc(4);
      chk("irq idle", 32'h0, {31'h0, compareIrq});
      raw(1'b0);
      chk("irq wait", 32'h1, {31'h0, compareIrq});
      bus(CT, 1'b1, EN | IE | BO);
      cyc(3);
      chk("irq w0", 32'h1, {31'h0, compareIrq});
      bus(CT, 1'b1, EN | IE | FL | BO);
      cyc(3);
      chk("irq w1", 32'h0, {31'h0, compareIrq});
      waitMode <= 1'b0;
      debugActive <= 1'b0;
      $display("test irq done");
      bus(OP, 1'b1, 32'h0);
      bus(CT, 1'b1, EN | PE | BO);
      raw(1'b1);
      chk("pin", 32'h3, {30'h0, compareOutputPinOe, compareOutputPin});
      bus(OP, 1'b1, 32'h2);
      cyc(4);
      chk("route", 32'h3, {30'h0, timerPinBlock, captureInput});
      raw(1'b0);
      chk("route low", 32'h2, {30'h0, timerPinBlock, captureInput});
      bus(OP, 1'b1, 32'h1);
      cyc(4);
      chk("pin off", 32'h0, {30'h0, compareOutputPinOe, timerPinBlock});
      $display("test pins done");
      bus(PM, 1'b1, 32'h1);
      refAbove <= 1'b1;
      bus(CT, 1'b1, EN | RS | BO);
      cyc(10);
      bus(CT, 1'b1, EN | RS | FL | BO);
      chk("ref", 32'h3, {30'h0, referenceSelect, referenceBufferEnable});
      rdc("ref result", CT, 32'hff, EN | RS | RE | BO);
      $display("test reference done");
      bus(LP, 1'b1, 32'h3);
      cyc(2);
      chk("lp refused", 32'h1, {31'h0, compareEnable});
      bus(LP, 1'b1, 32'h2);
      cyc(2);
      chk("stop3 off", 32'h0, {31'h0, compareEnable});
      refAbove <= 1'b0;
      cyc(10);
      refAbove <= 1'b1;
      cyc(10);
      bus(LP, 1'b1, 32'h0);
      cyc(10);
      rdc("stop3 resume", CT, 32'hff, EN | RS | RE | BO);
      bus(LP, 1'b1, 32'h2);
      nrst <= 1'b0;
      cyc(2);
      nrst <= 1'b1;
      rdc("stop3 reset", CT, 32'hff, 32'h0);
      bus(CT, 1'b1, EN | BO);
      bus(LP, 1'b1, 32'h1);
      cyc(2);
      chk("deep off", 32'h0, {31'h0, compareEnable});
      bus(LP, 1'b1, 32'h0);
      rdc("deep reset", CT, 32'hff, 32'h0);
      $display("test stop done");
      complete_run();
   end
endmodule
